// file: pkg/fcl_regs.vh
// Register indices, reset values and timing constants of the closed-loop feedback block.
`ifndef FCL_REGS_VH
`define FCL_REGS_VH
// Register indices; the byte address on the bus is four times the index.
`define FCL_IDX_PERIOD 24'h25_0A01
`define FCL_IDX_MODE 24'h25_0A02
`define FCL_IDX_DIR 24'h25_0A03
`define FCL_IDX_FILTER 24'h25_0A04
`define FCL_IDX_MASTER 24'h25_0A05
`define FCL_IDX_SLAVE 24'h25_0A06
`define FCL_IDX_POS 24'h25_0A07
`define FCL_IDX_SPEED 24'h25_0A08
`define FCL_IDX_TOL 24'h25_0A09
`define FCL_IDX_FORMAT 24'h25_0803
`define FCL_IDX_PREGEAR 24'h25_0804
`define FCL_IDX_STATUS 24'h25_0AF0
// Reset values.
`define FCL_RST_FORMAT 8'h01
`define FCL_RST_DIR 8'h01
`define FCL_RST_FILTER 16'h000A
`define FCL_RST_TOL 8'h06
`define FCL_RST_MODE 8'h00
// Input pulse formats.
`define FCL_FMT_UPDOWN 8'h00
`define FCL_FMT_PULSEDIR 8'h01
`define FCL_FMT_QUAD 8'h02
// Closed-loop selector values.
`define FCL_MODE_NORMAL 8'h00
`define FCL_MODE_POS 8'h01
`define FCL_MODE_VELPOS 8'h02
// Status bit positions.
`define FCL_ST_LOOP 0
`define FCL_ST_INDEX 1
`define FCL_ST_DIR 2
// Timing: sample interval in nanoseconds and clock period in nanoseconds.
`define FCL_SAMPLE_NS 250000
`define FCL_CLOCK_NS 8
`define FCL_SAMPLE_CYCLES (`FCL_SAMPLE_NS / `FCL_CLOCK_NS)
// Speed samples in one millisecond.
`define FCL_SAMPLES_PER_MS (1000000 / `FCL_SAMPLE_NS)
// Bus responses.
`define FCL_RESP_OKAY 2'h0
`define FCL_RESP_SLVERR 2'h2
`endif

// file: verilog/fcl_pulse_decoder.v
// Decoder that turns the pulse input lines into count steps for the selected format.
`timescale 1ns/100ps
`default_nettype none
`include "fcl_regs.vh"
module fcl_pulse_decoder (
  // Clock and reset.
  input wire clock,
  input wire resetn,
  // Pulse lines and active format.
  input wire line_a,
  input wire line_b,
  input wire [7:0] format,
  // Decoded step.
  output reg step,
  output reg step_up
);
  reg a_d; // Line A one cycle earlier.
  reg b_d; // Line B one cycle earlier.
  reg next_step; // Step in this cycle.
  reg next_up; // Direction of that step.

  // Decode edges according to the format.
  always @* begin
    next_step = 1'b0;
    next_up = 1'b1;
    case (format)
      `FCL_FMT_UPDOWN: begin
        // Rising edge on A counts up, on B counts down; both at once cancel.
        next_step = (line_a & ~a_d) ^ (line_b & ~b_d);
        next_up = line_a & ~a_d;
      end
      `FCL_FMT_QUAD: begin
        // One step per change of exactly one line; A leading B counts up.
        next_step = (line_a ^ a_d) ^ (line_b ^ b_d);
        next_up = line_a ^ b_d;
      end
      default: begin
        // Pulse on A, direction level on B.
        next_step = line_a & ~a_d;
        next_up = line_b;
      end
    endcase
  end

  // Register the line history and the decoded step.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      a_d <= 1'b0;
      b_d <= 1'b0;
      step <= 1'b0;
      step_up <= 1'b1;
    end else begin
      a_d <= line_a;
      b_d <= line_b;
      step <= next_step;
      step_up <= next_up;
    end
  end
endmodule // fcl_pulse_decoder
`default_nettype wire

// file: verilog/fcl_feedback.v
// Full closed-loop external encoder feedback with its AXI4-Lite register file.
`timescale 1ns/100ps
`default_nettype none
`include "fcl_regs.vh"
module fcl_feedback #(
  parameter SAMPLE_CYCLES = `FCL_SAMPLE_CYCLES
) (
  // Clock and reset.
  input wire clock,
  input wire resetn,
  // Pulse input port and motor feedback.
  input wire line_a,
  input wire line_b,
  input wire line_index,
  input wire [15:0] motor_speed,
  input wire [7:0] saved_format,
  // Block status.
  output reg pulse_cmd_enable,
  output reg loop_fault,
  // AXI4-Lite write channels.
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read channels.
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  // Software-visible settings.
  reg [31:0] index_period;
  reg [7:0] loop_mode;
  reg [7:0] ext_direction;
  reg [15:0] err_filter;
  reg [15:0] check_master;
  reg [15:0] check_slave;
  reg [7:0] ratio_tolerance_percent;
  reg [7:0] input_pulse_format;
  reg [31:0] pre_gear_pulse_count;
  // Format in use, fixed from one restart to the next.
  reg [7:0] active_format;
  reg format_loaded;
  // Position, speed and sample timing.
  reg [31:0] live_position;
  reg [31:0] external_position;
  reg [31:0] sample_position;
  reg [15:0] external_speed;
  reg [31:0] sample_count;
  reg sample_tick;
  // Index check state.
  reg [31:0] index_steps;
  reg index_seen;
  reg index_d;
  // Fault filters and sticky status.
  reg [17:0] dir_count;
  reg [17:0] ratio_count;
  reg [2:0] status;
  // Bus holding registers.
  reg aw_held;
  reg w_held;
  reg [23:0] w_index;
  reg w_addr_ok;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  // Decoder outputs.
  wire step;
  wire step_up;

  // Turn the pulse lines into steps with the format that was active at restart.
  fcl_pulse_decoder u_decoder (
    .clock(clock),
    .resetn(resetn),
    .line_a(line_a),
    .line_b(line_b),
    .format(active_format),
    .step(step),
    .step_up(step_up)
  );

  // Merge a bus write into a stored word under the byte strobes.
  function [31:0] merge;
    input [31:0] old_value;
    input [31:0] new_value;
    input [3:0] strb;
    integer i;
    begin
      merge = old_value;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = new_value[i*8 +: 8];
        end
      end
    end
  endfunction

  // Magnitude of a signed 16-bit speed.
  function [15:0] magnitude;
    input [15:0] value;
    begin
      magnitude = value[15] ? (~value + 16'h0001) : value;
    end
  endfunction

  // Write handshake, decode and effects.
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire hit = do_write & w_addr_ok;
  wire is_pregear = hit && (w_index == `FCL_IDX_PREGEAR);
  wire is_status = hit && (w_index == `FCL_IDX_STATUS);
  // The step adjusted by the direction setting: 1 keeps the wiring sense.
  wire count_up = step_up ^ ~ext_direction[0];
  // Ratio check products and tolerance comparison.
  wire [15:0] ext_mag = magnitude(external_speed);
  wire [15:0] motor_mag = magnitude(motor_speed);
  wire [31:0] ext_scaled = ext_mag * check_slave;
  wire [31:0] motor_scaled = motor_mag * check_master;
  wire [31:0] scaled_diff = (ext_scaled > motor_scaled) ? ext_scaled - motor_scaled : motor_scaled - ext_scaled;
  wire [39:0] tol_limit = motor_scaled * ratio_tolerance_percent;
  wire ratio_on = (loop_mode == `FCL_MODE_VELPOS) && (check_master != 16'h0000) && (check_slave != 16'h0000);
  wire ratio_bad = ratio_on && ({scaled_diff, 8'h00} > tol_limit);
  // Opposite signs with both encoders moving.
  wire dir_bad = (loop_mode != `FCL_MODE_NORMAL) && (external_speed != 16'h0000)
    && (motor_speed != 16'h0000) && (external_speed[15] != motor_speed[15]);
  // Detection time in samples.
  wire [17:0] filter_samples = {err_filter, 2'b00};
  wire index_rise = line_index & ~index_d;

  // Catch the saved format once after reset release; later writes wait for a restart.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      active_format <= `FCL_RST_FORMAT;
      format_loaded <= 1'b0;
    end else if (!format_loaded) begin
      active_format <= saved_format;
      format_loaded <= 1'b1;
    end
  end

  // Settings registers written over the bus.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      index_period <= 32'h0000_0000;
      loop_mode <= `FCL_RST_MODE;
      ext_direction <= `FCL_RST_DIR;
      err_filter <= `FCL_RST_FILTER;
      check_master <= 16'h0000;
      check_slave <= 16'h0000;
      ratio_tolerance_percent <= `FCL_RST_TOL;
      input_pulse_format <= `FCL_RST_FORMAT;
    end else if (!format_loaded) begin
      input_pulse_format <= saved_format;
    end else if (hit) begin
      case (w_index)
        `FCL_IDX_PERIOD: index_period <= merge(index_period, w_data, w_strb);
        `FCL_IDX_MODE: loop_mode <= w_strb[0] ? w_data[7:0] : loop_mode;
        `FCL_IDX_DIR: ext_direction <= w_strb[0] ? w_data[7:0] : ext_direction;
        `FCL_IDX_FILTER: err_filter <= {w_strb[1] ? w_data[15:8] : err_filter[15:8],
          w_strb[0] ? w_data[7:0] : err_filter[7:0]};
        `FCL_IDX_MASTER: check_master <= {w_strb[1] ? w_data[15:8] : check_master[15:8],
          w_strb[0] ? w_data[7:0] : check_master[7:0]};
        `FCL_IDX_SLAVE: check_slave <= {w_strb[1] ? w_data[15:8] : check_slave[15:8],
          w_strb[0] ? w_data[7:0] : check_slave[7:0]};
        `FCL_IDX_TOL: ratio_tolerance_percent <= w_strb[0] ? w_data[7:0] : ratio_tolerance_percent;
        `FCL_IDX_FORMAT: input_pulse_format <= w_strb[0] ? w_data[7:0] : input_pulse_format;
        default: begin
          // Other indices hold counters or status and are handled elsewhere.
        end
      endcase
    end
  end

  // Raw pulse count before gearing; a bus write replaces it, usually with zero.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pre_gear_pulse_count <= 32'h0000_0000;
    end else if (is_pregear) begin
      pre_gear_pulse_count <= merge(pre_gear_pulse_count, w_data, w_strb);
    end else if (step) begin
      pre_gear_pulse_count <= step_up ? pre_gear_pulse_count + 32'h0000_0001
        : pre_gear_pulse_count - 32'h0000_0001;
    end
  end

  // Live position and the sample timer that publishes position and speed.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      live_position <= 32'h0000_0000;
      external_position <= 32'h0000_0000;
      sample_position <= 32'h0000_0000;
      external_speed <= 16'h0000;
      sample_count <= 32'h0000_0000;
      sample_tick <= 1'b0;
    end else begin
      if (step) begin
        live_position <= count_up ? live_position + 32'h0000_0001 : live_position - 32'h0000_0001;
      end
      sample_tick <= 1'b0;
      if (sample_count >= SAMPLE_CYCLES - 1) begin
        sample_count <= 32'h0000_0000;
        sample_tick <= 1'b1;
        external_position <= live_position;
        external_speed <= live_position[15:0] - sample_position[15:0];
        sample_position <= live_position;
      end else begin
        sample_count <= sample_count + 32'h0000_0001;
      end
    end
  end

  // Count steps between index rises and compare with the configured period.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      index_d <= 1'b0;
      index_seen <= 1'b0;
      index_steps <= 32'h0000_0000;
    end else begin
      index_d <= line_index;
      if (index_rise) begin
        index_seen <= 1'b1;
        index_steps <= 32'h0000_0000;
      end else if (step) begin
        index_steps <= index_steps + 32'h0000_0001;
      end
    end
  end

  // Fault filters run once per sample; a clear by software loses to a new fault.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dir_count <= 18'h0_0000;
      ratio_count <= 18'h0_0000;
      status <= 3'b000;
    end else begin
      if (sample_tick) begin
        dir_count <= dir_bad ? ((dir_count == 18'h3_FFFF) ? dir_count : dir_count + 18'h0_0001) : 18'h0_0000;
        ratio_count <= ratio_bad ? ((ratio_count == 18'h3_FFFF) ? ratio_count : ratio_count + 18'h0_0001)
          : 18'h0_0000;
      end
      status[`FCL_ST_LOOP] <= (status[`FCL_ST_LOOP] & ~(is_status & w_strb[0] & w_data[`FCL_ST_LOOP]))
        | (dir_bad && dir_count >= filter_samples)
        | (ratio_bad && ratio_count >= filter_samples);
      status[`FCL_ST_DIR] <= (status[`FCL_ST_DIR] & ~(is_status & w_strb[0] & w_data[`FCL_ST_DIR]))
        | (dir_bad && dir_count >= filter_samples);
      status[`FCL_ST_INDEX] <= (status[`FCL_ST_INDEX] & ~(is_status & w_strb[0] & w_data[`FCL_ST_INDEX]))
        | (dir_bad && dir_count >= filter_samples)
        | (index_rise && index_seen && (index_period != 32'h0000_0000) && (index_steps != index_period));
    end
  end

  // Block status outputs: the pulse port serves only feedback in closed loop.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pulse_cmd_enable <= 1'b1;
      loop_fault <= 1'b0;
    end else begin
      pulse_cmd_enable <= (loop_mode == `FCL_MODE_NORMAL);
      loop_fault <= |status;
    end
  end

  // Write channels: hold address and data in either order, answer once both arrived.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FCL_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      w_index <= 24'h00_0000;
      w_addr_ok <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_held <= 1'b1;
        w_index <= s_axi_awaddr[25:2];
        w_addr_ok <= (s_axi_awaddr[31:26] == 6'h00) && (s_axi_awaddr[25:2] != `FCL_IDX_POS)
          && (s_axi_awaddr[25:2] != `FCL_IDX_SPEED) && writable(s_axi_awaddr[25:2]);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_addr_ok ? `FCL_RESP_OKAY : `FCL_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Indices that accept a write.
  function writable;
    input [23:0] idx;
    begin
      case (idx)
        `FCL_IDX_PERIOD, `FCL_IDX_MODE, `FCL_IDX_DIR, `FCL_IDX_FILTER, `FCL_IDX_MASTER, `FCL_IDX_SLAVE,
        `FCL_IDX_TOL, `FCL_IDX_FORMAT, `FCL_IDX_PREGEAR, `FCL_IDX_STATUS: writable = 1'b1;
        default: writable = 1'b0;
      endcase
    end
  endfunction

  // Read multiplexer; unmapped addresses answer zero with an error.
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;
  always @* begin
    next_rdata = 32'h0000_0000;
    next_rresp = `FCL_RESP_OKAY;
    if (s_axi_araddr[31:26] != 6'h00) begin
      next_rresp = `FCL_RESP_SLVERR;
    end else begin
      case (s_axi_araddr[25:2])
        `FCL_IDX_PERIOD: next_rdata = index_period;
        `FCL_IDX_MODE: next_rdata = {24'h00_0000, loop_mode};
        `FCL_IDX_DIR: next_rdata = {24'h00_0000, ext_direction};
        `FCL_IDX_FILTER: next_rdata = {16'h0000, err_filter};
        `FCL_IDX_MASTER: next_rdata = {16'h0000, check_master};
        `FCL_IDX_SLAVE: next_rdata = {16'h0000, check_slave};
        `FCL_IDX_POS: next_rdata = external_position;
        `FCL_IDX_SPEED: next_rdata = {16'h0000, external_speed};
        `FCL_IDX_TOL: next_rdata = {24'h00_0000, ratio_tolerance_percent};
        `FCL_IDX_FORMAT: next_rdata = {24'h00_0000, input_pulse_format};
        `FCL_IDX_PREGEAR: next_rdata = pre_gear_pulse_count;
        `FCL_IDX_STATUS: next_rdata = {29'h0000_0000, status};
        default: next_rresp = `FCL_RESP_SLVERR;
      endcase
    end
  end

  // Read channels: one read at a time, data one cycle after the address is taken.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `FCL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // fcl_feedback
`default_nettype wire

// file: tb/fcl_feedback_props.sv
// Concurrent checks on the ports of the closed-loop feedback block.
`timescale 1ns/100ps
`default_nettype none
`include "fcl_regs.vh"
module fcl_feedback_props (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Block status.
  input wire logic pulse_cmd_enable,
  input wire logic loop_fault,
  // Write channels.
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels.
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // Byte addresses of the read-only position and speed words.
  localparam logic [31:0] ADDR_POS = {6'h00, `FCL_IDX_POS, 2'b00};
  localparam logic [31:0] ADDR_SPEED = {6'h00, `FCL_IDX_SPEED, 2'b00};
  // Address handshakes.
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  property p_write_answer;
    aw_take && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write response missing");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_busy: assert property (p_b_busy) else $error("write taken while response pending");
  property p_read_answer;
    ar_take |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read data late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data changed while held");
  property p_ro_write;
    aw_take && (s_axi_awaddr == ADDR_POS || s_axi_awaddr == ADDR_SPEED)
      |-> ##[1:3] s_axi_bvalid && s_axi_bresp == `FCL_RESP_SLVERR;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write accepted");
  property p_unmapped_read;
    ar_take && s_axi_araddr == 32'h0000_0000 |=> s_axi_rresp == `FCL_RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read answered");
  property p_cmd_fall;
    $fell(pulse_cmd_enable) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_cmd_fall: assert property (p_cmd_fall) else $error("pulse command lost without a write");
  property p_fault_fall;
    $fell(loop_fault) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_fault_fall: assert property (p_fault_fall) else $error("fault cleared without a write");
  // Main scenarios reached.
  c_unmapped: cover property (ar_take && s_axi_araddr == 32'h0000_0000);
  c_fault: cover property ($rose(loop_fault));
  c_cmd_off: cover property ($fell(pulse_cmd_enable));
endmodule // fcl_feedback_props
bind fcl_feedback fcl_feedback_props u_fcl_feedback_props (.clock, .resetn,
  .pulse_cmd_enable, .loop_fault, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// file: tb/fcl_encoder_model.sv
// Behavioural load-side encoder driving the pulse input port.
`timescale 1ns/100ps
`default_nettype none
module fcl_encoder_model (
  // Clock that paces every line edge.
  input wire logic clock,
  // Encoder lines.
  output logic line_a,
  output logic line_b,
  output logic line_index
);
  // Quadrature position as a Gray step counter.
  logic [1:0] phase;
  // Lines idle low.
  initial begin
    phase = 2'b00;
    line_a = 1'b0;
    line_b = 1'b0;
    line_index = 1'b0;
  end
  // Makes n counts in format fmt; a gap of 8 or more cycles in quadrature, 16 or more in pulse formats, keeps the lines under 4 MHz.
  task automatic move(input int n, input logic up, input logic [7:0] fmt, input int gap);
    for (int i = 0; i < n; i++) begin
      if (fmt == 8'h02) begin
        phase = up ? phase + 2'b01 : phase - 2'b01;
        line_a <= (phase == 2'b01) || (phase == 2'b10);
        line_b <= phase[1];
        repeat (gap) @(posedge clock);
      end else begin
        line_a <= 1'b0;
        line_b <= (fmt == 8'h01) ? up : 1'b0;
        repeat (gap) @(posedge clock);
        if (fmt == 8'h00 && !up) begin
          line_b <= 1'b1;
        end else begin
          line_a <= 1'b1;
        end
        repeat (gap) @(posedge clock);
      end
    end
    // Pulse formats end with the pulse line low again.
    if (fmt != 8'h02) begin
      line_a <= 1'b0;
      line_b <= (fmt == 8'h01) ? line_b : 1'b0;
      repeat (gap) @(posedge clock);
    end
  endtask
  // One index pulse.
  task automatic index_pulse();
    line_index <= 1'b1;
    repeat (8) @(posedge clock);
    line_index <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
endmodule // fcl_encoder_model
`default_nettype wire

// file: tb/fcl_feedback_tb.sv
// Self-checking bench for the full closed-loop feedback block.
`timescale 1ns/100ps
`default_nettype none
`include "fcl_regs.vh"
module fcl_feedback_tb;
  // Short sample interval keeps the run brief.
  localparam int SC = 20;
  // Design signals.
  logic clock, resetn, line_a, line_b, line_index, pulse_cmd_enable, loop_fault;
  logic [15:0] motor_speed;
  logic [7:0] saved_format;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d, p0;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  // Counters of the run.
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  fcl_feedback #(.SAMPLE_CYCLES(SC)) u_fcl_feedback (.clock, .resetn, .line_a, .line_b, .line_index, .motor_speed,
    .saved_format, .pulse_cmd_enable, .loop_fault, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  fcl_encoder_model u_fcl_encoder_model (.clock, .line_a, .line_b, .line_index);
  // 125 MHz clock.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Cuts a hang short.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      $display("CHECK FAILED timeout expected finish seen hang");
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bus write; address and data go out together, each released once taken.
  task automatic wr(input logic [23:0] idx, input logic [31:0] v, input logic [1:0] er = `FCL_RESP_OKAY);
    s_axi_awaddr <= {6'h00, idx, 2'b00};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", er, s_axi_bresp);
  endtask
  // Bus read into d; bready and rready stay high all run.
  task automatic rd(input logic [23:0] idx, input logic [1:0] er);
    s_axi_araddr <= {6'h00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    chk("rresp", er, s_axi_rresp);
  endtask
  task automatic rdchk(input string what, input logic [23:0] idx, input logic [31:0] exp);
    rd(idx, `FCL_RESP_OKAY);
    chk(what, exp, d);
  endtask
  task automatic samples(input int n);
    repeat (n * SC) @(posedge clock);
  endtask
  // Moves the load encoder.
  task automatic mv(input int n, input logic up, input logic [7:0] f, input int g);
    u_fcl_encoder_model.move(n, up, f, g);
  endtask
  // Restart with a saved format, then clear the raw count.
  task automatic restart(input logic [7:0] fmt);
    saved_format <= fmt;
    resetn <= 1'b0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    wr(`FCL_IDX_PREGEAR, 8'h00);
  endtask
  // Main sequence.
  initial begin
    resetn = 1'b0;
    saved_format = 8'h01;
    motor_speed = 16'h0000;
    s_axi_awaddr = 32'h0000_0000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 32'h0000_0000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    restart(8'h01);
    chk("cmd enable", 1'b1, pulse_cmd_enable);
    rdchk("format", `FCL_IDX_FORMAT, 8'h01);
    rdchk("direction", `FCL_IDX_DIR, 8'h01);
    rdchk("tolerance", `FCL_IDX_TOL, 8'h06);
    rdchk("mode", `FCL_IDX_MODE, 8'h00);
    rdchk("filter", `FCL_IDX_FILTER, 8'h0A);
    wr(`FCL_IDX_POS, 16'h1234, `FCL_RESP_SLVERR);
    wr(`FCL_IDX_SPEED, 16'h1234, `FCL_RESP_SLVERR);
    rd(24'h00_0000, `FCL_RESP_SLVERR);
    chk("unmapped", 8'h00, d);
    rd(`FCL_IDX_POS, `FCL_RESP_OKAY);
    p0 = d;
    mv(5, 1'b1, 8'h01, 16);
    mv(3, 1'b0, 8'h01, 16);
    rdchk("pregear", `FCL_IDX_PREGEAR, 8'h02);
    samples(2);
    rdchk("position", `FCL_IDX_POS, p0 + 8'h02);
    rdchk("still speed", `FCL_IDX_SPEED, 8'h00);
    wr(`FCL_IDX_DIR, 8'h00);
    mv(4, 1'b1, 8'h01, 16);
    samples(2);
    rdchk("reversed", `FCL_IDX_POS, p0 - 8'h02);
    rdchk("raw count", `FCL_IDX_PREGEAR, 8'h06);
    wr(`FCL_IDX_FORMAT, 8'h02);
    rdchk("stored format", `FCL_IDX_FORMAT, 8'h02);
    mv(1, 1'b1, 8'h01, 16);
    rdchk("old format", `FCL_IDX_PREGEAR, 8'h07);
    restart(8'h00);
    mv(3, 1'b1, 8'h00, 128);
    mv(1, 1'b0, 8'h00, 128);
    rdchk("updown", `FCL_IDX_PREGEAR, 8'h02);
    restart(8'h02);
    rdchk("new format", `FCL_IDX_FORMAT, 8'h02);
    mv(8, 1'b1, 8'h02, 8);
    rdchk("quadrature", `FCL_IDX_PREGEAR, 8'h08);
    u_fcl_encoder_model.index_pulse();
    mv(5, 1'b1, 8'h02, 8);
    u_fcl_encoder_model.index_pulse();
    rdchk("no period", `FCL_IDX_STATUS, 8'h00);
    wr(`FCL_IDX_PERIOD, 8'h08);
    mv(8, 1'b1, 8'h02, 8);
    u_fcl_encoder_model.index_pulse();
    rdchk("period met", `FCL_IDX_STATUS, 8'h00);
    mv(5, 1'b1, 8'h02, 8);
    u_fcl_encoder_model.index_pulse();
    rdchk("period missed", `FCL_IDX_STATUS, 8'h02);
    chk("index fault", 1'b1, loop_fault);
    wr(`FCL_IDX_STATUS, 8'h07);
    wr(`FCL_IDX_FILTER, 8'h01);
    wr(`FCL_IDX_MODE, 8'h01);
    motor_speed <= 16'h000A;
    mv(40, 1'b1, 8'h02, 8);
    chk("same direction", 1'b0, loop_fault);
    chk("cmd disabled", 1'b0, pulse_cmd_enable);
    mv(6, 1'b0, 8'h02, 8);
    chk("short mismatch", 1'b0, loop_fault);
    mv(40, 1'b0, 8'h02, 8);
    chk("opposite", 1'b1, loop_fault);
    rdchk("dir status", `FCL_IDX_STATUS, 8'h07);
    // Let the speed settle at zero so the mismatch no longer re-sets the status.
    samples(2);
    wr(`FCL_IDX_STATUS, 8'h07);
    wr(`FCL_IDX_MODE, 8'h02);
    wr(`FCL_IDX_MASTER, 16'h03E8);
    wr(`FCL_IDX_SLAVE, 16'h03E8);
    motor_speed <= 16'h0002;
    fork
      mv(40, 1'b1, 8'h02, 10);
      begin
        samples(6);
        rdchk("speed", `FCL_IDX_SPEED, 8'h02);
      end
    join
    motor_speed <= 16'h0000;
    chk("ratio kept", 1'b0, loop_fault);
    wr(`FCL_IDX_SLAVE, 8'h00);
    motor_speed <= 16'h000A;
    samples(10);
    chk("ratio off", 1'b0, loop_fault);
    wr(`FCL_IDX_SLAVE, 16'h03E8);
    samples(10);
    rdchk("ratio fault", `FCL_IDX_STATUS, 8'h01);
    wrap_up();
  end
endmodule // fcl_feedback_tb
`default_nettype wire
